// ### hdl/amseq_consts.svh
// Constants of the converter mode and reset sequencer
`ifndef AMSEQ_CONSTS_SVH
`define AMSEQ_CONSTS_SVH

// Clock and timing
`define AMSEQ_MCLK_HZ          10000000
`define AMSEQ_POR_TIME_US      500
`define AMSEQ_START_NORM_X10   285
`define AMSEQ_START_TURBO_X10  1050
`define AMSEQ_MOD_DIV_NORM     2'h3
`define AMSEQ_MOD_DIV_TURBO    2'h1

// Slave address: fixed prefix, pin codes
`define AMSEQ_ADDR_PREFIX      3'h4
`define AMSEQ_GCALL_WRITE      8'h00
`define AMSEQ_GCALL_RESET      8'h06
`define AMSEQ_PIN_GND          2'h0
`define AMSEQ_PIN_SUPPLY       2'h1
`define AMSEQ_PIN_SDA          2'h2
`define AMSEQ_PIN_SCL          2'h3

// Command byte patterns, last bit ignored
`define AMSEQ_CMD_RESET        7'h03
`define AMSEQ_CMD_START        7'h04
`define AMSEQ_CMD_SLEEP        7'h01
`define AMSEQ_CMD_WREG_HI      4'h4

// Configuration bytes and field positions
`define AMSEQ_CFG_COUNT        4
`define AMSEQ_CFG_RESET        8'h00
`define AMSEQ_CFG_MODE_REG     2'h1
`define AMSEQ_CFG_CM_BIT       2
`define AMSEQ_CFG_TURBO_BIT    4
`define AMSEQ_CFG_DR_LSB       5

// Bit engine
`define AMSEQ_BIT_LAST         4'h7
`define AMSEQ_BIT_ACK          4'h8
`define AMSEQ_BIT_PRE          4'hf

`endif

// ### hdl/amseq_pkg.sv
// Types of the converter mode and reset sequencer
package amseq_pkg;

  typedef enum logic [2:0] {
    AMSEQ_IDLE_LP,
    AMSEQ_START_WAIT,
    AMSEQ_CONVERTING,
    AMSEQ_PD_PENDING,
    AMSEQ_POWERED_DOWN
  } amseq_state_t;

endpackage

// ### hdl/amseq_sync.sv
// Two-stage synchroniser for one pin level
`timescale 1ns/10ps
`default_nettype none

module amseq_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      level
);

  logic meta_q;

  // First stage is read only by the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_q <= RST_VAL;
      level  <= RST_VAL;
    end else begin
      meta_q <= pin;
      level  <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ### hdl/amseq_top.sv
// Converter mode and reset sequencer with bus slave front end
// Operation
// - Reset from power-on detection, external low reset pin, or bus reset command.
// - Any reset restores configuration defaults, enters low power, idles until start.
// - Power-up holds reset about 500 us after supplies are good.
// - Command bytes 06h and 07h reset; bus may continue immediately.
// - General-call software reset sequence also resets the device.
// - Mode bit change takes effect only at the next start command.
// - Single-shot mode does one conversion per start, then returns to low power.
// - Single-shot config write during conversion aborts and starts one fresh conversion.
// - Continuous mode stores each result and starts the next conversion at once.
// - Continuous first conversion starts 28.5 or 105 clock periods after start latch; the code waits 29 or 105.
// - Continuous config write during conversion restarts the current conversion.
// - Power-down lets the ongoing conversion finish, then switches analog off.
// - Powered down keeps configuration, accepts commands, performs no conversion.
// - Start in power-down wakes and converts per the current mode bit.
// - Normal speed default, modulator at a quarter of system clock.
// - Turbo speed runs the modulator twice as fast.
// - Operates only as bus slave, never initiates a transfer.
// - Bus lines are only pulled low or released, never driven high.
// - Address is 100, high-pin code, low-pin code; pins sensed four ways.
// - Address pins re-sensed between START and first falling clock of address.
// - Commands act only when latched on the eighth falling clock edge.
// - Byte 0000 100x is the start command.
// - Acknowledge general-call write; reset if the next byte is 06h.
`timescale 1ns/10ps
`default_nettype none
`include "amseq_consts.svh"

module amseq_top #(
  parameter int unsigned POR_CYCLES = `AMSEQ_POR_TIME_US * (`AMSEQ_MCLK_HZ / 1000000)
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       supplies_ok,
  input  wire logic       reset_pin_n,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       address_select_low_pin,
  input  wire logic       address_select_high_pin,
  input  wire logic       conversion_done,
  output logic            conv_start,
  output logic            conv_abort,
  output logic            result_store,
  output logic            converting,
  output logic            analog_power_on,
  output logic            oscillator_on,
  output logic            excitation_on,
  output logic            modulator_tick,
  output logic            turbo_active,
  output logic            conversion_mode_select,
  output logic [2:0]      data_rate_select,
  output logic [6:0]      slave_address
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic scl_s, sda_s, rstpin_s, sup_s, a_lo_s, a_hi_s;

  amseq_sync #(.RST_VAL(1'b1)) u_scl (.mclk(mclk), .reset(reset), .pin(scl_i), .level(scl_s));
  amseq_sync #(.RST_VAL(1'b1)) u_sda (.mclk(mclk), .reset(reset), .pin(sda_i), .level(sda_s));
  amseq_sync #(.RST_VAL(1'b1)) u_rst (.mclk(mclk), .reset(reset), .pin(reset_pin_n), .level(rstpin_s));
  amseq_sync #(.RST_VAL(1'b0)) u_sup (.mclk(mclk), .reset(reset), .pin(supplies_ok), .level(sup_s));
  amseq_sync #(.RST_VAL(1'b0)) u_alo (.mclk(mclk), .reset(reset), .pin(address_select_low_pin), .level(a_lo_s));
  amseq_sync #(.RST_VAL(1'b0)) u_ahi (.mclk(mclk), .reset(reset), .pin(address_select_high_pin), .level(a_hi_s));

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  localparam logic [12:0] POR_LAST = 13'(POR_CYCLES - 1);

  logic [12:0] por_cnt_q;
  logic        por_busy_q;
  logic        soft_rst_q;
  logic        hard_rst;
  logic        core_rst;

  always_ff @(posedge mclk) begin
    if (reset || !sup_s) begin
      por_cnt_q  <= 13'h0000;
      por_busy_q <= 1'b1;
    end else if (por_busy_q) begin
      por_cnt_q  <= por_cnt_q + 13'h0001;
      por_busy_q <= (por_cnt_q != POR_LAST);
    end
  end

  assign hard_rst = reset | por_busy_q | ~rstpin_s;
  assign core_rst = hard_rst | soft_rst_q;

  // ****************************************************************
  // Bus condition detection
  // ****************************************************************
  logic scl_p_q, sda_p_q;
  logic bus_start, bus_stop, scl_rise, scl_fall;

  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;

  // ****************************************************************
  // Address pin sensing
  // ****************************************************************
  logic       sense_q;
  logic       lo_hi_q, hi_hi_q, lo_diff_q, hi_diff_q;
  logic [1:0] lo_code_q, hi_code_q;
  logic [1:0] lo_code_d, hi_code_d;

  // classify each pin from its levels before START, at START and at first clock fall
  assign lo_code_d = lo_hi_q ? (a_lo_s ? `AMSEQ_PIN_SUPPLY : `AMSEQ_PIN_SCL)
                             : (lo_diff_q ? `AMSEQ_PIN_GND : `AMSEQ_PIN_SDA);
  assign hi_code_d = hi_hi_q ? (a_hi_s ? `AMSEQ_PIN_SUPPLY : `AMSEQ_PIN_SCL)
                             : (hi_diff_q ? `AMSEQ_PIN_GND : `AMSEQ_PIN_SDA);

  // re-sense inside the START to first falling clock window
  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      sense_q   <= 1'b0;
      lo_hi_q   <= 1'b0;
      hi_hi_q   <= 1'b0;
      lo_diff_q <= 1'b0;
      hi_diff_q <= 1'b0;
      lo_code_q <= `AMSEQ_PIN_GND;
      hi_code_q <= `AMSEQ_PIN_GND;
    end else if (bus_start) begin
      sense_q   <= 1'b1;
      lo_hi_q   <= a_lo_s;
      hi_hi_q   <= a_hi_s;
    end else if (sense_q && scl_fall) begin
      sense_q   <= 1'b0;
      lo_code_q <= lo_code_d;
      hi_code_q <= hi_code_d;
    end else begin
      // Data is low all through the window, so the idle level before START tells ground from data line
      lo_diff_q <= (lo_diff_q & sense_q) | (sda_s & ~a_lo_s);
      hi_diff_q <= (hi_diff_q & sense_q) | (sda_s & ~a_hi_s);
    end
  end

  // fixed prefix, high-pin code, low-pin code
  assign slave_address = {`AMSEQ_ADDR_PREFIX, hi_code_q, lo_code_q};

  // ****************************************************************
  // Slave bit engine
  // ****************************************************************
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [1:0] byte_idx_q;
  logic       active_q, matched_q, gcall_q, write_q, ack_q;
  logic       wreg_pend_q;
  logic [1:0] wreg_addr_q;
  logic       byte_done;
  logic       addr_hit, gcall_hit;
  logic       cmd_byte, data_byte, gc_byte;
  logic       cmd_reset, cmd_start, cmd_sleep, cmd_wreg;
  logic       gc_reset, cfg_write;

  // a byte acts only at its eighth falling clock edge
  assign byte_done = active_q & scl_fall & (bit_q == `AMSEQ_BIT_LAST);
  assign addr_hit  = (shift_q[7:1] == slave_address);
  assign gcall_hit = (shift_q == `AMSEQ_GCALL_WRITE);
  assign cmd_byte  = byte_done & matched_q & write_q & (byte_idx_q == 2'h1);
  assign data_byte = byte_done & matched_q & write_q & (byte_idx_q != 2'h1) & (byte_idx_q != 2'h0);
  assign gc_byte   = byte_done & gcall_q & (byte_idx_q == 2'h1);

  assign cmd_reset = cmd_byte & (shift_q[7:1] == `AMSEQ_CMD_RESET);
  assign cmd_start = cmd_byte & (shift_q[7:1] == `AMSEQ_CMD_START);
  assign cmd_sleep = cmd_byte & (shift_q[7:1] == `AMSEQ_CMD_SLEEP);
  assign cmd_wreg  = cmd_byte & (shift_q[7:4] == `AMSEQ_CMD_WREG_HI);
  // reset only after an acknowledged general-call write
  assign gc_reset  = gc_byte & (shift_q == `AMSEQ_GCALL_RESET);
  assign cfg_write = data_byte & wreg_pend_q;

  always_ff @(posedge mclk) begin
    if (hard_rst || bus_stop) begin
      active_q   <= 1'b0;
      matched_q  <= 1'b0;
      gcall_q    <= 1'b0;
      write_q    <= 1'b0;
      ack_q      <= 1'b0;
      bit_q      <= 4'h0;
      byte_idx_q <= 2'h0;
      shift_q    <= 8'h00;
    end else if (bus_start) begin
      active_q   <= 1'b1;
      matched_q  <= 1'b0;
      gcall_q    <= 1'b0;
      ack_q      <= 1'b0;
      // The clock fall that closes START is not a data bit
      bit_q      <= `AMSEQ_BIT_PRE;
      byte_idx_q <= 2'h0;
    end else if (active_q && scl_rise && bit_q != `AMSEQ_BIT_ACK) begin
      shift_q <= {shift_q[6:0], sda_s};
    end else if (byte_done) begin
      bit_q <= `AMSEQ_BIT_ACK;
      if (byte_idx_q == 2'h0) begin
        // acknowledge general-call address with write direction
        matched_q <= addr_hit;
        gcall_q   <= gcall_hit;
        write_q   <= ~shift_q[0] | gcall_hit;
        ack_q     <= addr_hit | gcall_hit;
        active_q  <= addr_hit | gcall_hit;
      end else begin
        ack_q <= write_q;
      end
    end else if (active_q && scl_fall) begin
      ack_q      <= 1'b0;
      bit_q      <= (bit_q == `AMSEQ_BIT_ACK) ? 4'h0 : bit_q + 4'h1;
      byte_idx_q <= (bit_q == `AMSEQ_BIT_ACK && byte_idx_q != 2'h3) ? byte_idx_q + 2'h1 : byte_idx_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (core_rst || bus_start) begin
      wreg_pend_q <= 1'b0;
      wreg_addr_q <= 2'h0;
    end else if (cmd_byte) begin
      wreg_pend_q <= cmd_wreg;
      wreg_addr_q <= shift_q[3:2];
    end else if (cfg_write) begin
      wreg_pend_q <= 1'b0;
    end
  end

  // answers only inside a master's transfer; read data left released
  // the data line is only pulled low, never driven high
  assign sda_o  = 1'b0;
  assign sda_oe = ack_q;

  // Soft reset pulse; the bit engine survives it so the transfer can finish
  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= cmd_reset | gc_reset;
    end
  end

  // ****************************************************************
  // Configuration bytes
  // ****************************************************************
  logic [7:0] cfg_q [`AMSEQ_CFG_COUNT];
  logic [7:0] mode_reg;

  always_ff @(posedge mclk) begin
    for (int i = 0; i < `AMSEQ_CFG_COUNT; i++) begin
      if (core_rst) begin
        cfg_q[i] <= `AMSEQ_CFG_RESET;
      end else if (cfg_write && wreg_addr_q == 2'(i)) begin
        cfg_q[i] <= shift_q;
      end
    end
  end

  assign mode_reg               = cfg_q[`AMSEQ_CFG_MODE_REG];
  assign conversion_mode_select = mode_reg[`AMSEQ_CFG_CM_BIT];
  assign data_rate_select       = mode_reg[`AMSEQ_CFG_DR_LSB +: 3];

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  localparam int NORM_CYC  = (`AMSEQ_START_NORM_X10 + 9) / 10;
  localparam int TURBO_CYC = (`AMSEQ_START_TURBO_X10 + 9) / 10;

  amseq_pkg::amseq_state_t state_q, state_d;
  logic       cont_q, cont_d;
  logic       turbo_q, turbo_d;
  logic [6:0] dly_q, dly_d;
  logic       start_d, abort_d, store_d;
  logic       busy;

  assign busy = (state_q == amseq_pkg::AMSEQ_CONVERTING) || (state_q == amseq_pkg::AMSEQ_PD_PENDING);

  always_comb begin
    state_d = state_q;
    cont_d  = cont_q;
    turbo_d = turbo_q;
    dly_d   = dly_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    store_d = 1'b0;
    if (cmd_start) begin
      // mode and speed are taken only at a start command
      // start wakes from power-down per current mode bit
      cont_d  = conversion_mode_select;
      turbo_d = mode_reg[`AMSEQ_CFG_TURBO_BIT];
      abort_d = busy;
      if (conversion_mode_select) begin
        // first continuous conversion after the start delay
        state_d = amseq_pkg::AMSEQ_START_WAIT;
        dly_d   = mode_reg[`AMSEQ_CFG_TURBO_BIT] ? 7'(TURBO_CYC - 1) : 7'(NORM_CYC - 1);
      end else begin
        state_d = amseq_pkg::AMSEQ_CONVERTING;
        start_d = 1'b1;
      end
    end else if (cmd_sleep) begin
      // defer power-down until the conversion completes
      state_d = busy ? amseq_pkg::AMSEQ_PD_PENDING : amseq_pkg::AMSEQ_POWERED_DOWN;
    end else begin
      unique case (state_q)
        amseq_pkg::AMSEQ_IDLE_LP, amseq_pkg::AMSEQ_POWERED_DOWN: begin
          state_d = state_q;
        end
        amseq_pkg::AMSEQ_START_WAIT: begin
          if (dly_q == 7'h00) begin
            state_d = amseq_pkg::AMSEQ_CONVERTING;
            start_d = 1'b1;
          end else begin
            dly_d = dly_q - 7'h01;
          end
        end
        amseq_pkg::AMSEQ_CONVERTING: begin
          if (conversion_done) begin
            store_d = 1'b1;
            // continuous mode chains the next conversion
            if (cont_q) begin
              start_d = 1'b1;
            end else begin
              state_d = amseq_pkg::AMSEQ_IDLE_LP;
            end
          end else if (cfg_write) begin
            // single-shot write restarts one fresh conversion
            // continuous write restarts the current conversion
            abort_d = 1'b1;
            start_d = 1'b1;
          end
        end
        amseq_pkg::AMSEQ_PD_PENDING: begin
          if (conversion_done) begin
            store_d = 1'b1;
            state_d = amseq_pkg::AMSEQ_POWERED_DOWN;
          end
        end
      endcase
    end
  end

  // any reset idles in low power
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      state_q <= amseq_pkg::AMSEQ_IDLE_LP;
      cont_q  <= 1'b0;
      turbo_q <= 1'b0;
      dly_q   <= 7'h00;
    end else begin
      state_q <= state_d;
      cont_q  <= cont_d;
      turbo_q <= turbo_d;
      dly_q   <= dly_d;
    end
  end

  // reset aborts a running conversion at once
  always_ff @(posedge mclk) begin
    if (reset) begin
      conv_start   <= 1'b0;
      conv_abort   <= 1'b0;
      result_store <= 1'b0;
    end else begin
      conv_start   <= start_d & ~core_rst;
      conv_abort   <= core_rst ? busy : abort_d;
      result_store <= store_d & ~core_rst;
    end
  end

  // ****************************************************************
  // Power domains and modulator clock
  // ****************************************************************
  logic [1:0] mod_cnt_q;
  logic [1:0] mod_last;

  // idle low power keeps only the excitation sources
  assign converting      = (state_q != amseq_pkg::AMSEQ_IDLE_LP) && (state_q != amseq_pkg::AMSEQ_POWERED_DOWN);
  assign analog_power_on = converting;
  assign oscillator_on   = converting;
  assign excitation_on   = (state_q != amseq_pkg::AMSEQ_POWERED_DOWN);
  assign turbo_active    = turbo_q;
  assign mod_last        = turbo_q ? `AMSEQ_MOD_DIV_TURBO : `AMSEQ_MOD_DIV_NORM;
  assign modulator_tick  = oscillator_on & (mod_cnt_q == mod_last);

  // Divider halts with the oscillator to save power
  always_ff @(posedge mclk) begin
    if (core_rst || !oscillator_on || mod_cnt_q == mod_last) begin
      mod_cnt_q <= 2'h0;
    end else begin
      mod_cnt_q <= mod_cnt_q + 2'h1;
    end
  end

endmodule

`default_nettype wire

// ### verif/amseq_host.sv
// Bus master model driving the sequencer's serial port
`timescale 1ns/10ps
`default_nettype none

module amseq_host (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Quarter bit of an 800 ns period; data moves a quarter after the clock falls
  task automatic q();
    repeat (2) @(negedge mclk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    q();
    scl_low = 1'b0;
    q();
    sda_low = 1'b1;
    q();
    scl_low = 1'b1;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl_low = 1'b0;
    q();
    sda_low = 1'b0;
    q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    q();
    scl_low = 1'b0;
    q();
    q();
    r = sda;
    scl_low = 1'b1;
    q();
  endtask
  // Most significant bit first, then the acknowledge bit with data released
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
endmodule

`default_nettype wire

// ### verif/amseq_properties.sv
// Port assertions of the converter mode and reset sequencer
`timescale 1ns/10ps
`default_nettype none

module amseq_properties (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       conversion_done,
  input wire logic       conv_start,
  input wire logic       result_store,
  input wire logic       converting,
  input wire logic       analog_power_on,
  input wire logic       oscillator_on,
  input wire logic       excitation_on,
  input wire logic       modulator_tick,
  input wire logic       turbo_active,
  input wire logic       conversion_mode_select,
  input wire logic [2:0] data_rate_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ************************************************************
  // Sequences
  // ************************************************************
  // Speed is read one cycle late, so either latch timing passes
  sequence cont_entry;
    $rose(converting) && conversion_mode_select;
  endsequence
  sequence quiet_tick(int n);
    !modulator_tick[*1] ##(n) (modulator_tick || !oscillator_on);
  endsequence
  // ************************************************************
  // Assertions
  // ************************************************************
  // pull low only
  open_drain_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  ack_clock_low_a: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("acknowledge raised while clock high");
  normal_delay_a: assert property (cont_entry ##1 !turbo_active |-> ##28 conv_start)
    else $error("normal first start not after 29 cycles");
  turbo_delay_a: assert property (cont_entry ##1 turbo_active |-> ##104 conv_start)
    else $error("turbo first start not after 105 cycles");
  normal_tick_a: assert property (modulator_tick && !turbo_active |=> !modulator_tick[*3] ##1
    (modulator_tick || !oscillator_on)) else $error("normal tick spacing wrong");
  turbo_tick_a: assert property (modulator_tick && turbo_active |=> quiet_tick(1))
    else $error("turbo tick spacing wrong");
  store_after_done_a: assert property (conversion_done && converting |=> result_store)
    else $error("no result store after done");
  store_restart_a: assert property (result_store |-> conv_start == converting)
    else $error("restart after store wrong");
  power_follow_a: assert property (analog_power_on == converting && oscillator_on == converting)
    else $error("analog power does not follow state");
  sleep_quiet_a: assert property (!excitation_on |-> !converting && !conv_start)
    else $error("conversion while powered down");
  reset_default_a: assert property ($fell(reset) |-> !converting && excitation_on &&
    !turbo_active && !conversion_mode_select && data_rate_select == 3'h0) else $error("reset defaults wrong");
endmodule

bind amseq_top amseq_properties i_amseq_properties (.*);

`default_nettype wire

// ### verif/test_adc_mode_sequencer.sv
// Self-checking testbench of the converter mode and reset sequencer
`timescale 1ns/10ps
`default_nettype none

module test_adc_mode_sequencer;
  logic       mclk, reset, supplies_ok, reset_pin_n, conversion_done, scl_low, sda_low;
  logic       sda_o, sda_oe, conv_start, conv_abort, result_store, converting, analog_power_on;
  logic       oscillator_on, excitation_on, modulator_tick, turbo_active, conversion_mode_select;
  logic [2:0] data_rate_select;
  logic [6:0] slave_address;
  logic [1:0] hi_src, lo_src;
  wire        scl = !scl_low;
  wire        sda = (sda_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  // Address pins strapped to ground, supply, data line or clock line
  wire        pin_lo = lo_src[1] ? (lo_src[0] ? scl : sda) : lo_src[0];
  wire        pin_hi = hi_src[1] ? (hi_src[0] ? scl : sda) : hi_src[0];
  int         err_total, checks, n_start, n_abort, n_store, b_start, b_abort, b_store;

  amseq_top #(.POR_CYCLES(20)) i_amseq_top (.mclk(mclk), .reset(reset), .supplies_ok(supplies_ok),
    .reset_pin_n(reset_pin_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_select_low_pin(pin_lo), .address_select_high_pin(pin_hi), .conversion_done(conversion_done),
    .conv_start(conv_start), .conv_abort(conv_abort), .result_store(result_store), .converting(converting),
    .analog_power_on(analog_power_on), .oscillator_on(oscillator_on), .excitation_on(excitation_on),
    .modulator_tick(modulator_tick), .turbo_active(turbo_active),
    .conversion_mode_select(conversion_mode_select), .data_rate_select(data_rate_select),
    .slave_address(slave_address));
  amseq_host i_amseq_host (.mclk(mclk), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = !mclk;
  end
  always @(posedge mclk) begin
    if (conv_start === 1'b1) n_start++;
    if (conv_abort === 1'b1) n_abort++;
    if (result_store === 1'b1) n_store++;
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cnt3(input int s, input int a, input int st, input string what);
    checks++;
    if (n_start - b_start != s || n_abort - b_abort != a || n_store - b_store != st) begin
      err_total++;
      $display("BAD %0t %s pulse counts %0d %0d %0d", $time, what, n_start - b_start,
        n_abort - b_abort, n_store - b_store);
    end
    b_start = n_start;
    b_abort = n_abort;
    b_store = n_store;
  endtask
  task automatic await_start();
    for (int k = 0; k < 300 && n_start == b_start; k++) @(negedge mclk);
    if (n_start == b_start) begin
      err_total++;
      $display("BAD %0t no conversion start", $time);
      conclude();
    end
  endtask
  task automatic txn(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1, input int n);
    logic ack;
    i_amseq_host.start();
    i_amseq_host.send(a, ack);
    chk({7'h0, ack}, 8'h00, "address ack");
    if (n > 0) i_amseq_host.send(b0, ack);
    if (n > 1) i_amseq_host.send(b1, ack);
    chk({7'h0, ack}, 8'h00, "byte ack");
    i_amseq_host.stop();
  endtask
  task automatic cmd(input logic [7:0] c);
    txn({3'h4, hi_src, lo_src, 1'b0}, c, 8'h00, 1);
  endtask
  task automatic wreg(input logic [1:0] r, input logic [7:0] d);
    txn({3'h4, hi_src, lo_src, 1'b0}, {4'h4, r, 2'h0}, d, 2);
  endtask
  task automatic finish_conv();
    @(negedge mclk);
    conversion_done = 1'b1;
    @(negedge mclk);
    conversion_done = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_address();
    logic ack;
    for (int i = 0; i < 16; i++) begin
      hi_src = i[3:2];
      lo_src = i[1:0];
      txn({3'h4, hi_src, lo_src, 1'b0}, 8'h00, 8'h00, 0);
      chk({1'b0, slave_address}, {4'h4, i[3:0]}, "pin address");
    end
    hi_src = 2'h1;
    lo_src = 2'h0;
    i_amseq_host.start();
    i_amseq_host.send(8'h60, ack);
    chk({7'h0, ack}, 8'h01, "foreign address");
    i_amseq_host.stop();
    $display("address test done");
  endtask
  task automatic test_single();
    cmd(8'h09);
    cnt3(1, 0, 0, "single start");
    wreg(2'h0, 8'h00);
    cnt3(1, 1, 0, "single rewrite");
    chk({7'h0, converting}, 8'h01, "single busy");
    finish_conv();
    cnt3(0, 0, 1, "single end");
    chk({4'h0, converting, oscillator_on, analog_power_on, excitation_on}, 8'h01, "low power");
    $display("single test done");
  endtask
  task automatic test_cont();
    wreg(2'h1, 8'h24);
    cnt3(0, 0, 0, "mode write");
    chk({4'h0, conversion_mode_select, data_rate_select}, 8'h09, "config");
    cmd(8'h08); // start right after mode
    await_start();
    cnt3(1, 0, 0, "first start");
    finish_conv();
    cnt3(1, 0, 1, "next start");
    wreg(2'h0, 8'h00);
    cnt3(1, 1, 0, "restart");
    cmd(8'h02); // stop by power-down
    chk({6'h0, converting, excitation_on}, 8'h03, "deferred sleep");
    finish_conv();
    cnt3(0, 0, 1, "sleep entry");
    chk({6'h0, converting, excitation_on}, 8'h00, "asleep");
    wreg(2'h1, 8'h34);
    cnt3(0, 0, 0, "asleep write");
    chk({4'h0, conversion_mode_select, data_rate_select}, 8'h09, "kept config");
    cmd(8'h08);
    await_start();
    cnt3(1, 0, 0, "wake");
    chk({6'h0, converting, turbo_active}, 8'h03, "turbo run");
    cmd(8'h02);
    finish_conv();
    cnt3(0, 0, 1, "turbo sleep");
    $display("continuous test done");
  endtask
  task automatic test_resets();
    for (int k = 0; k < 5; k++) begin
      wreg(2'h1, 8'h34);
      cmd(8'h08);
      await_start();
      cnt3(1, 0, 0, "pre reset");
      case (k)
        0: cmd(8'h06);
        1: cmd(8'h07);
        2: txn(8'h00, 8'h06, 8'h00, 1);
        3: begin
          reset_pin_n = 1'b0;
          repeat (10) @(negedge mclk);
          reset_pin_n = 1'b1;
          repeat (40) @(negedge mclk);
        end
        default: begin
          supplies_ok = 1'b0;
          repeat (10) @(negedge mclk);
          supplies_ok = 1'b1;
          repeat (40) @(negedge mclk);
        end
      endcase
      cnt3(0, 1, 0, "reset abort");
      chk({converting, excitation_on, conversion_mode_select, turbo_active, 1'b0, data_rate_select},
        8'h40, "after reset");
    end
    $display("reset test done");
  endtask

  initial begin
    reset = 1'b1;
    supplies_ok = 1'b1;
    reset_pin_n = 1'b1;
    conversion_done = 1'b0;
    hi_src = 2'h0;
    lo_src = 2'h0;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    repeat (40) @(negedge mclk);
    chk({1'b0, slave_address}, 8'h40, "reset address");
    chk({5'h0, converting, excitation_on, turbo_active}, 8'h02, "reset state");
    test_address();
    test_single();
    test_cont();
    test_resets();
    conclude();
  end
endmodule

`default_nettype wire
